// File: ufbg_pkg.sv
// constants and helpers shared by the fractional baud generator
package ufbg_pkg;
    localparam int          UFBG_BYTE_W  = 8;
    localparam int          UFBG_DIV_W   = 16;
    localparam int          UFBG_FRAC_W  = 4;
    localparam int          UFBG_ACC_W   = 6;
    localparam int          UFBG_IER_W   = 10;
    localparam int          UFBG_OVERSAMPLE = 16;

    localparam logic [31:0] UFBG_DATA_ADDR  = 32'hE000_C000;
    localparam logic [31:0] UFBG_IER_ADDR   = 32'hE000_C004;
    localparam logic [31:0] UFBG_LCR_ADDR   = 32'hE000_C00C;
    localparam logic [31:0] UFBG_FRAC_ADDR  = 32'hE000_C028;

    localparam int          UFBG_ACCESS_BIT = 7;
    localparam int          UFBG_ADD_LSB    = 0;
    localparam int          UFBG_MUL_LSB    = 4;

    localparam logic [7:0]  UFBG_DIV_LOW_RST  = 8'h01;
    localparam logic [7:0]  UFBG_DIV_HIGH_RST = 8'h00;
    localparam logic [7:0]  UFBG_LCR_RST      = 8'h00;
    localparam logic [3:0]  UFBG_ADD_RST      = 4'h0;
    localparam logic [3:0]  UFBG_MUL_RST      = 4'h1;
    localparam logic [9:0]  UFBG_IER_RST      = 10'h000;
    localparam logic [9:0]  UFBG_IER_MASK     = 10'h307;

    typedef logic [UFBG_DIV_W-1:0] ufbg_div_t;

    // zero divides as one so the counter never wraps at minus one
    function automatic ufbg_div_t ufbg_eff_div(input logic [7:0] hi,
                                               input logic [7:0] lo);
        ufbg_div_t d;
        d = {hi, lo};
        if (d == 16'h0000) begin
            d = 16'h0001;
        end
        return d;
    endfunction
endpackage

// File: ufbg_presc_if.sv
// link between register file and fractional prescaler
`timescale 1ns/100ps
interface ufbg_presc_if;
    import ufbg_pkg::*;
    logic [UFBG_FRAC_W-1:0] mul;
    logic [UFBG_FRAC_W-1:0] add;
    logic                   tick;
    modport cfg   (output mul, output add, input tick);
    modport presc (input mul, input add, output tick);
endinterface

// File: ufbg_frac_presc.sv
// fractional prescaler: passes mul of every mul+add bus clocks
`timescale 1ns/100ps
module ufbg_frac_presc (
    input  wire logic    sys_clk_i,
    input  wire logic    reset_n_i,
    ufbg_presc_if.presc  frac
);
    import ufbg_pkg::*;

    logic [UFBG_ACC_W-1:0] acc_r;
    logic [UFBG_ACC_W-1:0] acc_nxt;
    logic                  tick_r;
    logic                  tick_nxt;
    logic [UFBG_ACC_W-1:0] sum;
    logic [UFBG_ACC_W-1:0] modulo;

    // accumulator steps by mul, wraps at mul+add: add clocks dropped, evenly
    always_comb begin
        modulo   = UFBG_ACC_W'(frac.mul) + UFBG_ACC_W'(frac.add);
        sum      = acc_r + UFBG_ACC_W'(frac.mul);
        acc_nxt  = sum;
        tick_nxt = 1'b0;
        if (acc_r >= modulo) begin
            // left over after a config change shrank the modulus
            acc_nxt  = '0;
            tick_nxt = 1'b1;
        end else if (sum >= modulo) begin
            acc_nxt  = sum - modulo;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign frac.tick = tick_r;

    property pass_through_p;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (frac.add == 4'h0 && frac.mul != 4'h0) [*2] |-> tick_r;
    endproperty
    frac_pass_through_a: assert property (pass_through_p)
        else $error("prescaler dropped a clock with add value zero");

    frac_drop_spread_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        ($stable(frac.add) && $stable(frac.mul) && frac.mul != 4'h0
         && frac.add <= frac.mul && !tick_r) |=> tick_r)
        else $error("prescaler dropped two clocks in a row");

    frac_drop_cov_c: cover property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        frac.add != 4'h0 && !tick_r);
endmodule

// File: ufbg_top.sv
// register file and divisor of the fractional baud generator
`timescale 1ns/100ps
module ufbg_top (
    input  wire logic                       sys_clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [31:0]                paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    input  wire logic [ufbg_pkg::UFBG_BYTE_W-1:0] rx_data_i,
    output logic                            rx_read_o,
    output logic                            tx_write_o,
    output logic      [ufbg_pkg::UFBG_BYTE_W-1:0] tx_data_o,
    output logic      [ufbg_pkg::UFBG_IER_W-1:0]  int_enable_o,
    output logic      [ufbg_pkg::UFBG_BYTE_W-1:0] line_control_o,
    output logic                            baud16_o
);
    import ufbg_pkg::*;

    ufbg_presc_if frac ();

    ufbg_frac_presc u_presc (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .frac      (frac.presc)
    );

    // register state
    logic [7:0]            div_low_r;
    logic [7:0]            div_low_nxt;
    logic [7:0]            div_high_r;
    logic [7:0]            div_high_nxt;
    logic [7:0]            lcr_r;
    logic [7:0]            lcr_nxt;
    logic [3:0]            add_r;
    logic [3:0]            add_nxt;
    logic [3:0]            mul_r;
    logic [3:0]            mul_nxt;
    logic [UFBG_IER_W-1:0] ier_r;
    logic [UFBG_IER_W-1:0] ier_nxt;
    logic [31:0]           prdata_nxt;
    logic                  pready_nxt;
    logic                  rx_read_nxt;
    logic                  tx_write_nxt;
    logic [7:0]            tx_data_nxt;

    logic                  setup;
    logic                  wr;
    logic                  rd;
    logic                  div_access;
    logic                  sel_data;
    logic                  sel_ier;
    logic                  sel_lcr;
    logic                  sel_frac;
    logic                  div_wr;

    assign div_access = lcr_r[UFBG_ACCESS_BIT];
    assign setup      = psel_i && !penable_i;
    assign wr         = psel_i && penable_i && pwrite_i;
    assign rd         = psel_i && penable_i && !pwrite_i;
    assign sel_data   = (paddr_i == UFBG_DATA_ADDR);
    assign sel_ier    = (paddr_i == UFBG_IER_ADDR);
    assign sel_lcr    = (paddr_i == UFBG_LCR_ADDR);
    assign sel_frac   = (paddr_i == UFBG_FRAC_ADDR);
    assign div_wr     = wr && div_access && (sel_data || sel_ier);

    assign frac.mul = mul_r;
    assign frac.add = add_r;

    always_comb begin
        div_low_nxt  = div_low_r;
        div_high_nxt = div_high_r;
        lcr_nxt      = lcr_r;
        add_nxt      = add_r;
        mul_nxt      = mul_r;
        ier_nxt      = ier_r;
        tx_write_nxt = 1'b0;
        tx_data_nxt  = tx_data_o;
        rx_read_nxt  = rd && sel_data && !div_access;
        if (wr) begin
            if (sel_data && div_access) begin
                div_low_nxt = pwdata_i[7:0];
            end
            if (sel_ier && div_access) begin
                div_high_nxt = pwdata_i[7:0];
            end
            if (sel_data && !div_access) begin
                tx_write_nxt = 1'b1;
                tx_data_nxt  = pwdata_i[7:0];
            end
            if (sel_ier && !div_access) begin
                ier_nxt = pwdata_i[UFBG_IER_W-1:0] & UFBG_IER_MASK;
            end
            if (sel_lcr) begin
                lcr_nxt = pwdata_i[7:0];
            end
            if (sel_frac) begin
                // upper bits are dropped, never stored
                add_nxt = pwdata_i[UFBG_ADD_LSB +: UFBG_FRAC_W];
                mul_nxt = pwdata_i[UFBG_MUL_LSB +: UFBG_FRAC_W];
            end
        end
    end

    // read data is staged in the setup phase so access runs with no wait
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        pready_nxt = setup;
        if (setup && !pwrite_i) begin
            if (sel_data) begin
                prdata_nxt[7:0] = div_access ? div_low_r : rx_data_i;
            end else if (sel_ier) begin
                prdata_nxt[UFBG_IER_W-1:0] =
                    div_access ? {2'b00, div_high_r} : ier_r;
            end else if (sel_lcr) begin
                prdata_nxt[7:0] = lcr_r;
            end else if (sel_frac) begin
                prdata_nxt[7:0] = {mul_r, add_r};
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_low_r    <= UFBG_DIV_LOW_RST;
            div_high_r   <= UFBG_DIV_HIGH_RST;
            lcr_r        <= UFBG_LCR_RST;
            add_r        <= UFBG_ADD_RST;
            mul_r        <= UFBG_MUL_RST;
            ier_r        <= UFBG_IER_RST;
            prdata_o     <= 32'h0000_0000;
            pready_o     <= 1'b0;
            rx_read_o    <= 1'b0;
            tx_write_o   <= 1'b0;
            tx_data_o    <= 8'h00;
        end else begin
            div_low_r    <= div_low_nxt;
            div_high_r   <= div_high_nxt;
            lcr_r        <= lcr_nxt;
            add_r        <= add_nxt;
            mul_r        <= mul_nxt;
            ier_r        <= ier_nxt;
            prdata_o     <= prdata_nxt;
            pready_o     <= pready_nxt;
            rx_read_o    <= rx_read_nxt;
            tx_write_o   <= tx_write_nxt;
            tx_data_o    <= tx_data_nxt;
        end
    end

    assign int_enable_o   = ier_r;
    assign line_control_o = lcr_r;

    // divisor: one baud16 pulse per eff_div prescaler ticks
    ufbg_div_t div_eff;
    ufbg_div_t cnt_r;
    ufbg_div_t cnt_nxt;
    logic      b16_nxt;
    logic      wrap;

    assign div_eff = ufbg_eff_div(div_high_r, div_low_r);
    // >= rather than == so a shrunk divisor cannot strand the count
    assign wrap    = frac.tick && !div_wr && (cnt_r >= div_eff - 16'h0001);

    always_comb begin
        cnt_nxt = cnt_r;
        b16_nxt = 1'b0;
        if (div_wr) begin
            cnt_nxt = '0;
        end else if (wrap) begin
            cnt_nxt = '0;
            b16_nxt = 1'b1;
        end else if (frac.tick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r    <= '0;
            baud16_o <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            baud16_o <= b16_nxt;
        end
    end

    // helper state read only by the checks below
    ufbg_div_t h_cnt_r;
    logic      h_dirty_r;
    logic      h_first_r;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            h_cnt_r   <= '0;
            h_dirty_r <= 1'b1;
            h_first_r <= 1'b1;
        end else begin
            h_first_r <= 1'b0;
            if (wrap) begin
                h_cnt_r   <= '0;
                h_dirty_r <= 1'b0;
            end else if (frac.tick) begin
                h_cnt_r <= h_cnt_r + 16'h0001;
            end
            if (div_wr) begin
                h_dirty_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    reset_values_a: assert property (h_first_r |->
        div_low_r == UFBG_DIV_LOW_RST && div_high_r == UFBG_DIV_HIGH_RST
        && mul_r == UFBG_MUL_RST && add_r == UFBG_ADD_RST
        && lcr_r == UFBG_LCR_RST)
        else $error("registers left reset with wrong values");
    baud_tick_source_a: assert property (baud16_o |-> $past(frac.tick))
        else $error("baud16 pulse without a prescaler tick");
    divisor_period_a: assert property (wrap && !h_dirty_r |->
        h_cnt_r + 16'h0001 == div_eff)
        else $error("baud16 period differs from divisor");
    zero_as_one_a: assert property (
        frac.tick && !div_wr && div_low_r == 8'h00 && div_high_r == 8'h00
        |=> baud16_o)
        else $error("zero divisor did not divide by one");
    latch_gated_a: assert property (
        wr && sel_data && !div_access |=> $stable(div_low_r) && tx_write_o)
        else $error("low latch written with access bit clear");
    high_latch_a: assert property (
        wr && sel_ier && div_access |=> div_high_r == $past(pwdata_i[7:0])
        && $stable(ier_r))
        else $error("high latch write misrouted");
    frac_write_a: assert property (
        wr && sel_frac |=> {mul_r, add_r} == $past(pwdata_i[7:0]))
        else $error("prescale control write lost");
    frac_upper_zero_a: assert property (
        setup && !pwrite_i && sel_frac |=> prdata_o[31:8] == 24'h000000
        && pready_o)
        else $error("prescale control upper bits not zero");
    access_bit_a: assert property (
        wr && sel_lcr |=> div_access == $past(pwdata_i[UFBG_ACCESS_BIT]))
        else $error("access bit not taken from bit 7");

    baud_run_c: cover property (baud16_o ##[1:40] baud16_o);
    frac_baud_c: cover property (add_r != 4'h0 && baud16_o);
    tx_write_c: cover property (tx_write_o);
    latch_read_c: cover property (rd && sel_data && div_access);
endmodule

// File: ufbg_top_test.sv
// self-checking testbench of the fractional baud generator
`timescale 1ns/100ps
module ufbg_top_test;
    import ufbg_pkg::*;
    logic        sys_clk_i   = 1'b0;
    logic        reset_n_i   = 1'b0;
    logic        psel_i      = 1'b0;
    logic        penable_i   = 1'b0;
    logic        pwrite_i    = 1'b0;
    logic [31:0] paddr_i     = 32'h0;
    logic [31:0] pwdata_i    = 32'h0;
    logic [7:0]  rx_data_i   = 8'h00;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        rx_read_o;
    logic        tx_write_o;
    logic [7:0]  tx_data_o;
    logic [9:0]  int_enable_o;
    logic [7:0]  line_control_o;
    logic        baud16_o;
    logic [31:0] rd_v;
    int          hits;
    int          bad_count   = 0;
    int          tests_run   = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    ufbg_top dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .rx_data_i(rx_data_i),
        .rx_read_o(rx_read_o), .tx_write_o(tx_write_o),
        .tx_data_o(tx_data_o), .int_enable_o(int_enable_o),
        .line_control_o(line_control_o), .baud16_o(baud16_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one zero-wait bus transfer; request held until pready is sampled
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge sys_clk_i);
        #1;
        psel_i    = 1'b1;
        penable_i = 1'b0;
        pwrite_i  = wr;
        paddr_i   = a;
        pwdata_i  = d;
        @(posedge sys_clk_i);
        #1;
        penable_i = 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        r = prdata_o;
        check({31'h0, pready_o}, 32'h1);
        #1;
        psel_i    = 1'b0;
        penable_i = 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h0, d);
    endtask

    task automatic count_baud(input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(posedge sys_clk_i);
            #1;
            if (baud16_o === 1'b1) n++;
        end
    endtask

    task automatic set_div(input logic [7:0] hi, input logic [7:0] lo);
        wr(UFBG_LCR_ADDR, 32'h80);
        wr(UFBG_DATA_ADDR, {24'h0, lo});
        wr(UFBG_IER_ADDR, {24'h0, hi});
        wr(UFBG_LCR_ADDR, 32'h00);
    endtask

    task automatic t_reset;
        count_baud(20, hits);
        check(hits, 20);
        rd(UFBG_LCR_ADDR, rd_v);
        check(rd_v, 32'h00);
        rd(UFBG_FRAC_ADDR, rd_v);
        check({24'h0, rd_v[7:0]}, 32'h10);
        wr(UFBG_LCR_ADDR, 32'h80);
        rd(UFBG_DATA_ADDR, rd_v);
        check(rd_v, 32'h01);
        rd(UFBG_IER_ADDR, rd_v);
        check(rd_v, 32'h00);
        wr(UFBG_LCR_ADDR, 32'h00);
    endtask

    task automatic t_route;
        rx_data_i = 8'hA5;
        rd(UFBG_DATA_ADDR, rd_v);
        check(rd_v, 32'hA5);
        check({31'h0, rx_read_o}, 32'h1);
        wr(UFBG_DATA_ADDR, 32'h3C);
        check({31'h0, tx_write_o}, 32'h1);
        check({24'h0, tx_data_o}, 32'h3C);
        wr(UFBG_IER_ADDR, 32'hFFFF_FFFF);
        check({22'h0, int_enable_o}, 32'h307);
        wr(UFBG_LCR_ADDR, 32'h80);
        check({24'h0, line_control_o}, 32'h80);
        rd(UFBG_IER_ADDR, rd_v);
        check(rd_v, 32'h00);
        rd(UFBG_DATA_ADDR, rd_v);
        check(rd_v, 32'h01);
        check({31'h0, rx_read_o}, 32'h0);
        wr(UFBG_DATA_ADDR, 32'h01);
        check({31'h0, tx_write_o}, 32'h0);
        rd(32'hE000_C008, rd_v);
        check(rd_v, 32'h0);
        wr(UFBG_LCR_ADDR, 32'h00);
    endtask

    // the byte-swapped divisor 0x0201 would give one pulse, not two
    task automatic t_divisor;
        logic [7:0] his [4] = '{8'h00, 8'h00, 8'h01, 8'h01};
        logic [7:0] los [4] = '{8'h03, 8'h00, 8'h00, 8'h02};
        int         win [4] = '{30, 20, 768, 516};
        int         exp [4] = '{10, 20, 3, 2};
        for (int i = 0; i < 4; i++) begin
            set_div(his[i], los[i]);
            count_baud(win[i], hits);
            check(hits, exp[i]);
        end
    endtask

    // windows span whole repeats of the tick pattern, so counts are exact
    // fields in range; low latch 3 or more whenever add is set
    task automatic t_frac;
        logic [3:0] mul [7] = '{4'd5, 4'd1, 4'd3, 4'd5, 4'd7, 4'd15, 4'd1};
        logic [3:0] add [7] = '{4'd0, 4'd1, 4'd1, 4'd2, 4'd12, 4'd15, 4'd15};
        logic [7:0] lo  [7] = '{8'd2, 8'd3, 8'd3, 8'd3, 8'd4, 8'd3, 8'd3};
        for (int i = 0; i < 7; i++) begin
            set_div(8'h00, lo[i]);
            // no characters move here, so the change is safe
            wr(UFBG_FRAC_ADDR, {24'h0, mul[i], add[i]});
            rd(UFBG_FRAC_ADDR, rd_v);
            check({24'h0, rd_v[7:0]}, {24'h0, mul[i], add[i]});
            repeat (64) @(posedge sys_clk_i);
            #1;
            count_baud(40 * int'(lo[i]) * (int'(mul[i]) + int'(add[i])),
                       hits);
            check(hits, 40 * int'(mul[i]));
        end
    endtask

    // bunched dropped ticks would give uneven gaps between pulses
    task automatic t_even;
        int gap;
        set_div(8'h00, 8'h03);
        wr(UFBG_FRAC_ADDR, 32'h22);
        repeat (32) @(posedge sys_clk_i);
        #1;
        gap = 0;
        while (baud16_o !== 1'b1 && gap < 16) begin
            @(posedge sys_clk_i);
            #1;
            gap++;
        end
        repeat (5) begin
            gap = 0;
            do begin
                @(posedge sys_clk_i);
                #1;
                gap++;
            end while (baud16_o !== 1'b1 && gap < 16);
            check(gap, 6);
        end
        wr(UFBG_FRAC_ADDR, 32'h10);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk_i);
        #1;
        reset_n_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        t_reset();
        t_route();
        t_divisor();
        t_frac();
        t_even();
        print_verdict();
    end

    // the whole run needs roughly 12600 cycles
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        bad_count++;
        $display("watchdog expired at %0t", $time);
        print_verdict();
    end
endmodule
